// ---- verilog/seq_pkg.sv ----
// Shared constants and types for the start-up and power-down sequencer
package seq_pkg;

    // Clock rate and hard-reset pulse capture
    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned HARD_RESET_NS   = 200;
    localparam int unsigned HARD_RESET_CYC  = HARD_RESET_NS / CLK_PERIOD_NS;

    // Power-on hold-off after all supplies and the pin are good
    localparam int unsigned POR_HOLD_CYC    = 16;

    // Default cycles for VCO calibration and loop start-up
    localparam int unsigned CAL_CYC         = 64;
    localparam int unsigned LOOP_START_CYC  = 32;

    // Serial interface encodings chosen by strap pin one
    localparam logic SERIAL_IS_I2C          = 1'b0;
    localparam logic SERIAL_IS_SPI          = 1'b1;

    localparam int unsigned PAGE_W          = 2;

    typedef enum logic [2:0] {
        ST_DOWN,
        ST_POR,
        ST_CAL,
        ST_LOOP,
        ST_RUN
    } seq_state_t;

    // Captured start-up straps
    typedef struct packed {
        logic              spi_mode;
        logic [PAGE_W-1:0] rom_page;
    } strap_t;

    // Supply and reference status inputs
    typedef struct packed {
        logic core_supply_ok;
        logic pin_above_vih;
        logic crystal_ref_valid;
    } supply_t;

    // Status of the oscillators and loops
    typedef struct packed {
        logic cal_done;
        logic cal_fail;
        logic loops_running;
        logic osc_three_lock;
    } seq_status_t;

endpackage

// ---- verilog/sync2.sv ----
// Two-flop level synchroniser
`timescale 1ns/10ps
module sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Level in and out
    input  wire logic din,
    output logic      dout
);
    logic meta_r;
    logic meta_nxt;
    logic dout_r;
    logic dout_nxt;

    always_comb begin
        meta_nxt = din;
        dout_nxt = meta_r;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RESET_VAL;
            dout_r <= RESET_VAL;
        end else begin
            meta_r <= meta_nxt;
            dout_r <= dout_nxt;
        end
    end

    assign dout = dout_r;
endmodule

// ---- verilog/startup_power_down_sequencer.sv ----
// Start-up, power-on hold-off, strap capture and calibration sequencing
//
// Summary of operation
// - Pin low disables device and serial interface
// - Pin rising starts POR then start-up
// - Strap one picks SPI high, I2C low
// - Straps zero and two pick ROM page
// - Hold reset until supplies and pin good
// - Oscillators one, two calibrate against crystal
// - Soft reset reruns calibration and loop start
// - Oscillator three locks while device enabled and crystal valid
// - Serial registers reachable only while pin high
`timescale 1ns/10ps
module startup_power_down_sequencer #(
    parameter int unsigned POR_CYC  = seq_pkg::POR_HOLD_CYC,
    parameter int unsigned CAL_CYC  = seq_pkg::CAL_CYC,
    parameter int unsigned LOOP_CYC = seq_pkg::LOOP_START_CYC
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // Power-down pin and straps
    input  wire logic                  power_down_n_pin,
    input  wire logic                  strap_pin_zero,
    input  wire logic                  strap_pin_one,
    input  wire logic                  strap_pin_two,
    // Analog conditions, already synchronous
    input  wire seq_pkg::supply_t      supply,
    // Soft reset from the register file
    input  wire logic                  soft_reset_bit,
    // Calibration result for oscillators one and two
    input  wire logic                  cal_ok,
    // Outputs
    output seq_pkg::strap_t            straps,
    output logic                       serial_enable,
    output logic                       device_enable,
    output logic                       cal_start,
    output seq_pkg::seq_status_t       status,
    output seq_pkg::seq_state_t        state
);
    localparam int CNT_W = 16;

    logic pin_sync;

    // Pin brought into the system clock domain
    sync2 #(.RESET_VAL(1'b0)) u_pin_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      (power_down_n_pin),
        .dout     (pin_sync)
    );

    seq_pkg::seq_state_t   state_r,   state_nxt;
    logic [CNT_W-1:0]      cnt_r,     cnt_nxt;
    seq_pkg::strap_t       straps_r,  straps_nxt;
    seq_pkg::seq_status_t  status_r,  status_nxt;
    logic                  ser_en_r,  ser_en_nxt;
    logic                  dev_en_r,  dev_en_nxt;
    logic                  cal_st_r,  cal_st_nxt;
    logic                  soft_d_r,  soft_d_nxt;
    logic                  soft_rise;
    logic                  supplies_good;
    logic                  por_end;
    logic                  cal_end;
    logic                  loop_end;
    logic                  rerun;
    logic                  cal_failed;

    // Rising edge of the soft-reset bit; the flop starts low like the idle bit
    always_comb begin
        soft_d_nxt = soft_reset_bit;
        soft_rise  = soft_reset_bit && !soft_d_r;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_d_r <= 1'b0;
        end else begin
            soft_d_r <= soft_d_nxt;
        end
    end

    // End-of-step events shared by the state, strap, status and pulse groups
    assign supplies_good = supply.core_supply_ok && supply.pin_above_vih;
    assign por_end       = pin_sync && (state_r == seq_pkg::ST_POR) && supplies_good
                           && (cnt_r >= CNT_W'(POR_CYC - 1));
    assign cal_end       = pin_sync && (state_r == seq_pkg::ST_CAL)
                           && (cnt_r >= CNT_W'(CAL_CYC - 1));
    assign loop_end      = pin_sync && (state_r == seq_pkg::ST_LOOP)
                           && (cnt_r >= CNT_W'(LOOP_CYC - 1));
    assign rerun         = pin_sync && (state_r == seq_pkg::ST_RUN) && soft_rise;
    // Unstable crystal at calibration leaves loops unlocked
    assign cal_failed    = !(cal_ok && supply.crystal_ref_valid);

    // Sequencer state and step counter
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        if (!pin_sync) begin
            state_nxt = seq_pkg::ST_DOWN;
            cnt_nxt   = '0;
        end else begin
            unique case (state_r)
                seq_pkg::ST_DOWN: begin
                    state_nxt = seq_pkg::ST_POR;
                    cnt_nxt   = '0;
                end
                seq_pkg::ST_POR: begin
                    if (!supplies_good) begin
                        cnt_nxt = '0;
                    end else if (por_end) begin
                        state_nxt = seq_pkg::ST_CAL;
                        cnt_nxt   = '0;
                    end else begin
                        cnt_nxt = cnt_r + CNT_W'(1);
                    end
                end
                seq_pkg::ST_CAL: begin
                    if (cal_end) begin
                        state_nxt = cal_failed ? seq_pkg::ST_RUN
                                               : seq_pkg::ST_LOOP;
                        cnt_nxt   = '0;
                    end else begin
                        cnt_nxt = cnt_r + CNT_W'(1);
                    end
                end
                seq_pkg::ST_LOOP: begin
                    if (loop_end) begin
                        state_nxt = seq_pkg::ST_RUN;
                        cnt_nxt   = '0;
                    end else begin
                        cnt_nxt = cnt_r + CNT_W'(1);
                    end
                end
                seq_pkg::ST_RUN: begin
                    if (rerun) begin
                        state_nxt = seq_pkg::ST_CAL;
                        cnt_nxt   = '0;
                    end
                end
                default: begin
                    // Unused codes fall back to power-down
                    state_nxt = seq_pkg::ST_DOWN;
                    cnt_nxt   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= seq_pkg::ST_DOWN;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Straps are taken once, on the edge that leaves the hold-off
    always_comb begin
        straps_nxt = straps_r;
        if (por_end) begin
            straps_nxt.spi_mode = strap_pin_one;
            straps_nxt.rom_page = {strap_pin_two, strap_pin_zero};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            straps_r <= '0;
        end else begin
            straps_r <= straps_nxt;
        end
    end

    // Calibration and loop status; a soft reset clears the results it reruns
    always_comb begin
        status_nxt = status_r;
        // Third oscillator is factory trimmed; it follows the crystal while the device is enabled
        status_nxt.osc_three_lock = dev_en_r && supply.crystal_ref_valid;
        if (!pin_sync) begin
            status_nxt = '0;
        end else if (cal_end) begin
            status_nxt.cal_done = 1'b1;
            status_nxt.cal_fail = cal_failed;
        end else if (loop_end) begin
            status_nxt.loops_running = 1'b1;
        end else if (rerun) begin
            status_nxt.cal_done      = 1'b0;
            status_nxt.cal_fail      = 1'b0;
            status_nxt.loops_running = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= '0;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Calibration pulse and enables
    always_comb begin
        cal_st_nxt = por_end || rerun;
        // Serial port live once straps are taken, until the pin drops
        ser_en_nxt = pin_sync && (state_r != seq_pkg::ST_DOWN)
                              && (state_r != seq_pkg::ST_POR)
                              && (state_nxt != seq_pkg::ST_POR);
        dev_en_nxt = pin_sync && (state_nxt != seq_pkg::ST_DOWN)
                              && (state_nxt != seq_pkg::ST_POR);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_en_r <= 1'b0;
            dev_en_r <= 1'b0;
            cal_st_r <= 1'b0;
        end else begin
            ser_en_r <= ser_en_nxt;
            dev_en_r <= dev_en_nxt;
            cal_st_r <= cal_st_nxt;
        end
    end

    assign straps        = straps_r;
    assign serial_enable = ser_en_r;
    assign device_enable = dev_en_r;
    assign cal_start     = cal_st_r;
    assign status        = status_r;
    assign state         = state_r;
endmodule

// ---- testbench/startup_power_down_sequencer_sva.sv ----
// Checker for the start-up and power-down sequencer ports
`timescale 1ns/10ps
module seq_checker (
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    // Pins and conditions
    input wire logic                 power_down_n_pin,
    input wire logic                 strap_pin_zero,
    input wire logic                 strap_pin_one,
    input wire logic                 strap_pin_two,
    input wire seq_pkg::supply_t     supply,
    input wire logic                 soft_reset_bit,
    // Outputs watched
    input wire seq_pkg::strap_t      straps,
    input wire logic                 serial_enable,
    input wire logic                 device_enable,
    input wire logic                 cal_start,
    input wire seq_pkg::seq_status_t status,
    input wire seq_pkg::seq_state_t  state
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_pin_low_down: assert property (!power_down_n_pin [*4] |-> state == seq_pkg::ST_DOWN)
        else $error("pin low but not powered down");
    a_enables_off: assert property (state == seq_pkg::ST_DOWN |=> !serial_enable && !device_enable)
        else $error("enable high while down");
    a_down_to_por: assert property ((state == seq_pkg::ST_DOWN) ##1 (state != seq_pkg::ST_DOWN)
        |-> state == seq_pkg::ST_POR) else $error("left down state not into hold-off");
    a_por_hold: assert property (state == seq_pkg::ST_POR && !supply.core_supply_ok
        |=> state != seq_pkg::ST_CAL) else $error("hold-off left with bad supply");
    a_cal_pulse: assert property (cal_start |-> device_enable && state == seq_pkg::ST_CAL ##1 !cal_start)
        else $error("calibration start pulse wrong");
    a_strap_latch: assert property (state == seq_pkg::ST_CAL && $past(state) == seq_pkg::ST_POR
        |-> straps == {$past(strap_pin_one), $past(strap_pin_two), $past(strap_pin_zero)})
        else $error("straps not latched at hold-off exit");
    a_straps_held: assert property (state != seq_pkg::ST_POR |=> $stable(straps))
        else $error("straps changed outside hold-off exit");
    a_soft_rerun: assert property (state == seq_pkg::ST_RUN && $rose(soft_reset_bit)
        |-> ##[1:3] cal_start) else $error("soft reset did not rerun calibration");
    a_osc_lock: assert property (device_enable && supply.crystal_ref_valid
        && $past(power_down_n_pin, 2) |=> status.osc_three_lock)
        else $error("oscillator three not locked");
endmodule
bind startup_power_down_sequencer seq_checker chk (.core_clk(core_clk), .rst_n(rst_n),
    .power_down_n_pin(power_down_n_pin), .strap_pin_zero(strap_pin_zero),
    .strap_pin_one(strap_pin_one), .strap_pin_two(strap_pin_two), .supply(supply),
    .soft_reset_bit(soft_reset_bit), .straps(straps), .serial_enable(serial_enable),
    .device_enable(device_enable), .cal_start(cal_start), .status(status), .state(state));

// ---- testbench/host_model.sv ----
// Host model driving the power-down pin and the strap pins
`timescale 1ns/10ps
module host_model (
    // Clock
    input  wire logic  core_clk,
    // Pin and straps, bit 2 strap one, bit 1 strap two, bit 0 strap zero
    output logic       power_down_n_pin,
    output logic [2:0] strap_bus
);
    initial begin
        power_down_n_pin = 1'b0;
        strap_bus        = 3'h0;
    end
    task automatic hard_reset();
        power_down_n_pin = 1'b0;
        repeat (6) @(negedge core_clk);
    endtask
    task automatic power_up(input logic [2:0] s);
        strap_bus = s;
        @(negedge core_clk);
        power_down_n_pin = 1'b1;
    endtask
endmodule

// ---- testbench/startup_power_down_sequencer_tb_top.sv ----
// Testbench for the start-up and power-down sequencer
`timescale 1ns/10ps
module startup_power_down_sequencer_tb_top;
    logic                 core_clk, rst_n, soft_reset_bit, cal_ok, power_down_n_pin;
    logic [2:0]           strap_bus;
    seq_pkg::supply_t     supply;
    seq_pkg::strap_t      straps;
    logic                 serial_enable, device_enable, cal_start;
    seq_pkg::seq_status_t status;
    seq_pkg::seq_state_t  state, last_state;
    logic [3:0]           exp_q[$];
    logic [3:0]           exp_now;
    int                   err_total = 0;
    int                   samples_checked = 0;
    host_model host (.core_clk(core_clk), .power_down_n_pin(power_down_n_pin),
        .strap_bus(strap_bus));
    startup_power_down_sequencer #(.POR_CYC(4), .CAL_CYC(8), .LOOP_CYC(4)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .power_down_n_pin(power_down_n_pin),
        .strap_pin_zero(strap_bus[0]), .strap_pin_one(strap_bus[2]),
        .strap_pin_two(strap_bus[1]), .supply(supply), .soft_reset_bit(soft_reset_bit),
        .cal_ok(cal_ok), .straps(straps), .serial_enable(serial_enable),
        .device_enable(device_enable), .cal_start(cal_start), .status(status), .state(state));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_state(input seq_pkg::seq_state_t s);
        int n;
        n = 0;
        while (state !== s && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        if (state !== s) begin
            err_total++;
            end_sim();
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Each entry into run compares the latched straps and the failure flag
    always @(negedge core_clk) begin
        last_state <= state;
        if (state === seq_pkg::ST_RUN && last_state !== seq_pkg::ST_RUN) begin
            exp_now = exp_q.pop_front();
            check({straps, status.cal_fail}, exp_now);
            check({status.cal_done, status.loops_running, serial_enable, device_enable},
                {1'b1, !exp_now[0], 2'b11});
        end
    end
    initial begin
        logic [2:0] s;
        logic       ok;
        rst_n          = 1'b0;
        soft_reset_bit = 1'b0;
        cal_ok         = 1'b0;
        supply         = '0;
        last_state     = seq_pkg::ST_DOWN;
        void'($urandom(32'h8949));
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            s      = i[2:0];
            ok     = 1'($urandom);
            cal_ok = ok;
            supply = 3'b010;
            host.power_up(s);
            repeat (20) @(negedge core_clk);
            check({3'h0, state === seq_pkg::ST_POR}, 4'h1);
            supply.core_supply_ok    = 1'b1;
            supply.crystal_ref_valid = i[0];
            exp_q.push_back({s, !(ok && i[0])});
            wait_state(seq_pkg::ST_RUN);
            host.strap_bus           = ~s;
            supply.crystal_ref_valid = 1'b1;
            cal_ok                   = 1'b1;
            exp_q.push_back({s, 1'b0});
            soft_reset_bit = 1'b1;
            @(negedge core_clk);
            soft_reset_bit = 1'b0;
            wait_state(seq_pkg::ST_CAL);
            wait_state(seq_pkg::ST_RUN);
            check({3'h0, status.osc_three_lock}, 4'h1);
            host.hard_reset();
            check({2'h0, device_enable, serial_enable}, 4'h0);
            $display("test %0d done", i);
        end
        end_sim();
    end
endmodule
